// ==== core/acsms_link_if.sv ====
// Carries a received serial byte from the link clock domain to the core.
// The byte stays stable from the rise of rx_avail until chip select rises or the next byte ends.
`timescale 1ns/1ns
`default_nettype none
interface acsms_link_if;
  logic [7:0] rx_byte;
  logic       rx_avail;
  modport link (output rx_byte, output rx_avail);
  modport core (input rx_byte, input rx_avail);
endinterface : acsms_link_if
`default_nettype wire

// ==== core/acsms_link_rx.sv ====
// Serial receiver on the host's link clock.
// Assumes the link clock only runs while chip select is low or tied low.
`timescale 1ns/1ns
`default_nettype none
module acsms_link_rx (
  input  wire logic  i_sclk,
  input  wire logic  i_cs_n,
  input  wire logic  i_sdio,
  acsms_link_if.link lnk
);
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [6:0] shreg;
    logic [7:0] data;
    logic       avail;
  } acsms_rx_s;

  acsms_rx_s rx_q;
  acsms_rx_s rx_d;

  // ****************************************************************
  // Shift in MSB first; a level marks a finished byte
  // ****************************************************************
  always_comb begin
    rx_d         = rx_q;
    rx_d.bit_cnt = rx_q.bit_cnt + 3'h1;
    rx_d.shreg   = {rx_q.shreg[5:0], i_sdio};
    if (rx_q.bit_cnt == 3'h0) begin
      rx_d.avail = 1'b0;
    end
    if (rx_q.bit_cnt == 3'h7) begin
      rx_d.data  = {rx_q.shreg, i_sdio};
      rx_d.avail = 1'b1;
    end
  end

  // The frame ends the partial byte; the link clock may stop right after
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  assign lnk.rx_byte  = rx_q.data;
  assign lnk.rx_avail = rx_q.avail;
endmodule : acsms_link_rx
`default_nettype wire

// ==== core/acsms_pkg.sv ====
// Constants and types shared by the calibration and sleep mode sequencer.
// Assumes a 10 MHz core clock; conversion timing is counted in that clock.
package acsms_pkg;

  // ****************************************************************
  // Mode codes of the operation mode field
  // ****************************************************************
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_SELF    = 3'h1;
  localparam logic [2:0] MODE_SYS_OFS = 3'h2;
  localparam logic [2:0] MODE_SYS_FS  = 3'h3;
  localparam logic [2:0] MODE_PSEUDO  = 3'h4;
  localparam logic [2:0] MODE_BKGND   = 3'h5;
  localparam logic [2:0] MODE_SLEEP   = 3'h6;
  localparam logic [2:0] MODE_UNDEF   = 3'h7;
  localparam logic [2:0] MODE_RESET   = MODE_NORMAL;

  // ****************************************************************
  // Step lengths in conversion periods
  // ****************************************************************
  localparam logic [2:0] OFS_CONV_MASTER = 3'h3;
  localparam logic [2:0] OFS_CONV_SLAVE  = 3'h4;
  localparam logic [2:0] GAIN_CONV       = 3'h3;
  localparam logic [2:0] FILL_CONV       = 3'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 100;
  localparam int PWRUP_TIME_NS   = 2000;
  localparam int PWRUP_CYCLES    = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_PERIOD_US  = 100;
  localparam int CONV_CYCLES_DEF = CONV_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // ****************************************************************
  // Serial command byte layout
  // ****************************************************************
  localparam int CMD_MODE_WR_BIT = 7;
  localparam int CMD_MODE_MSB    = 2;

  typedef enum logic [1:0] {CAP_INPUT, CAP_SHORT, CAP_REF} acsms_cap_e;

  typedef enum logic [3:0] {
    ST_NORMAL, ST_SELF_OFS, ST_SELF_GAIN, ST_SYS_CAL, ST_PS_OFS, ST_PS_GAIN,
    ST_FILL, ST_BG_OFS, ST_BG_FILL1, ST_BG_GAIN, ST_BG_FILL2, ST_SLEEP,
    ST_WAKE_PWR, ST_WAKE_CONV
  } acsms_state_e;

endpackage : acsms_pkg

// ==== core/acsms_top.sv ====
// Calibration and sleep mode sequencer of a delta-sigma converter controller.
// Assumes a 10 MHz core clock and a host that sends mode bytes on the serial link.
// Contract
// - Code 100 starts pseudo calibration next cycle
// - Data-ready stays high during calibration sequence
// - Pseudo offset on input, three/four periods
// - Then capacitor on reference, three gain conversions
// - Field clears, three fills, then data-ready
// - Code 101 enters background calibration next cycle
// - Background offset shorted three; first slave four
// - Three fills, data-ready low, gain step
// - Three fills, data-ready low, offset restarts
// - Background results at one sixth rate
// - Background continues until another code written
// - Code 110 enters sleep until rewritten
// - Sleep powers down analog; bias, reference stay
// - Chip select low wakes serial port
// - Slave tied: ordinary command wakes the port
// - Wake: power-up, one conversion, then mode
// - Data-ready high through first two cycles
// - Code 001 runs self-calibration then normal
// - Code 010 runs system offset then normal
`timescale 1ns/1ns
`default_nettype none
module acsms_top
  import acsms_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_sdio,
  input  wire logic       i_slave_mode,
  input  wire logic       i_bias_enable,
  input  wire logic       i_internal_ref_output_enable,
  output logic            o_conversion_valid_n,
  output logic [2:0]      o_operation_mode_field,
  output acsms_cap_e      o_cap_sel,
  output logic            o_offset_cal_active,
  output logic            o_gain_cal_active,
  output logic            o_analog_pwr_en,
  output logic            o_bias_pwr_en,
  output logic            o_ref_pwr_en,
  output logic            o_serial_awake
);

  typedef struct packed {
    acsms_state_e state;
    logic [2:0]   mode;
    logic [2:0]   step;
    logic [15:0]  conv_cnt;
    logic [15:0]  pwr_cnt;
    logic         conversion_valid_n_n;
    logic         bg_first;
    logic         suppress;
    logic         port_awake;
    logic [2:0]   cs_sync;
    logic [2:0]   sdio_sync;
    logic [2:0]   avail_sync;
    logic         cs_lvl;
    logic         sdio_lvl;
    logic         avail_lvl;
    logic         bias_en;
    logic         ref_en;
  } acsms_core_s;

  acsms_core_s  q;
  acsms_core_s  d;
  acsms_link_if lnk ();

  acsms_link_rx u_rx (
    .i_sclk (i_sclk),
    .i_cs_n (i_cs_n),
    .i_sdio (i_sdio),
    .lnk    (lnk.link)
  );

  logic       tick;
  logic [2:0] ofs_last;
  logic [2:0] bg_ofs_last;
  logic       byte_rx;
  logic [2:0] rx_code;
  logic       mode_wr;

  assign tick        = (q.conv_cnt == 16'(CONV_CYCLES - 1));
  assign ofs_last    = (i_slave_mode ? OFS_CONV_SLAVE : OFS_CONV_MASTER) - 3'h1;
  assign bg_ofs_last = ((i_slave_mode && q.bg_first) ? OFS_CONV_SLAVE : OFS_CONV_MASTER) - 3'h1;
  // Byte is stable well before its level is seen here, so it is read directly
  assign byte_rx     = q.avail_lvl == 1'b0 && q.avail_sync[2:1] == 2'b11;
  assign rx_code     = lnk.rx_byte[CMD_MODE_MSB:0];
  assign mode_wr     = byte_rx && lnk.rx_byte[CMD_MODE_WR_BIT] && (q.port_awake || i_slave_mode);

  // First state of a newly sampled mode at a conversion boundary
  function automatic acsms_state_e enter_mode(input logic [2:0] m);
    acsms_state_e s;
    s = ST_NORMAL;
    case (m)
      MODE_SELF:    s = ST_SELF_OFS;
      MODE_SYS_OFS: s = ST_SYS_CAL;
      MODE_SYS_FS:  s = ST_SYS_CAL;
      MODE_PSEUDO:  s = ST_PS_OFS;
      MODE_BKGND:   s = ST_BG_OFS;
      MODE_SLEEP:   s = ST_SLEEP;
      default:      s = ST_NORMAL;
    endcase
    return s;
  endfunction : enter_mode

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d            = q;
    d.conversion_valid_n_n     = 1'b1;
    d.cs_sync    = {q.cs_sync[1:0], i_cs_n};
    d.sdio_sync  = {q.sdio_sync[1:0], i_sdio};
    d.avail_sync = {q.avail_sync[1:0], lnk.rx_avail};
    if (q.cs_sync[2] == q.cs_sync[1]) begin
      d.cs_lvl = q.cs_sync[2];
    end
    if (q.sdio_sync[2] == q.sdio_sync[1]) begin
      d.sdio_lvl = q.sdio_sync[2];
    end
    if (q.avail_sync[2] == q.avail_sync[1]) begin
      d.avail_lvl = q.avail_sync[2];
    end
    // Reference and bias follow the host bits only; waking never restores them
    d.bias_en = i_bias_enable;
    d.ref_en  = i_internal_ref_output_enable;

    // Serial port wake-up while asleep
    if (!q.port_awake) begin
      if (q.cs_lvl && q.cs_sync[2:1] == 2'b00) begin
        d.port_awake = 1'b1;
      end
      if (!i_slave_mode && q.sdio_lvl && q.sdio_sync[2:1] == 2'b00) begin
        d.port_awake = 1'b1;
      end
      if (i_slave_mode && byte_rx) begin
        d.port_awake = 1'b1;
      end
    end
    // Undefined code leaves the field untouched
    if (mode_wr && rx_code != MODE_UNDEF) begin
      d.mode = rx_code;
    end

    // Conversion timer stops while the analog section is down
    if (q.state == ST_SLEEP || q.state == ST_WAKE_PWR) begin
      d.conv_cnt = '0;
    end else if (tick) begin
      d.conv_cnt = '0;
    end else begin
      d.conv_cnt = q.conv_cnt + 16'h1;
    end

    case (q.state)
      ST_SLEEP: begin
        d.port_awake = d.port_awake;
        if (q.mode != MODE_SLEEP) begin
          d.state   = ST_WAKE_PWR;
          d.pwr_cnt = '0;
        end
      end
      ST_WAKE_PWR: begin
        d.pwr_cnt = q.pwr_cnt + 16'h1;
        if (q.pwr_cnt == 16'(PWRUP_CYCLES - 1)) begin
          d.state = ST_WAKE_CONV;
        end
      end
      default: begin
        if (tick) begin
          d.step = q.step + 3'h1;
          case (q.state)
            ST_WAKE_CONV: begin
              // New mode only now; a normal mode still hides the next result
              d.state    = enter_mode(q.mode);
              d.step     = '0;
              d.suppress = 1'b1;
              d.bg_first = 1'b1;
            end
            ST_NORMAL: begin
              if (q.mode == MODE_NORMAL) begin
                d.conversion_valid_n_n   = q.suppress;
                d.suppress = 1'b0;
              end
              d.state    = enter_mode(q.mode);
              d.step     = '0;
              d.bg_first = 1'b1;
            end
            ST_SELF_OFS, ST_PS_OFS: begin
              if (q.step == ofs_last) begin
                d.state = (q.state == ST_PS_OFS) ? ST_PS_GAIN : ST_SELF_GAIN;
                d.step  = '0;
              end
            end
            ST_SELF_GAIN, ST_PS_GAIN: begin
              if (q.step == GAIN_CONV - 3'h1) begin
                d.state = ST_FILL;
                d.step  = '0;
                d.mode  = MODE_NORMAL;
              end
            end
            ST_SYS_CAL: begin
              // One conversion with data-ready high: enter the last fill slot
              if (q.step == ofs_last) begin
                d.state = ST_FILL;
                d.step  = FILL_CONV - 3'h1;
                d.mode  = MODE_NORMAL;
              end
            end
            ST_FILL: begin
              if (q.step == FILL_CONV - 3'h1) begin
                d.state  = ST_NORMAL;
                d.conversion_valid_n_n = 1'b0;
              end
            end
            default: begin
              // Background loop: 12 periods, two results, so one in six
              if (q.mode != MODE_BKGND) begin
                d.state = enter_mode(q.mode);
                d.step  = '0;
              end else begin
                case (q.state)
                  ST_BG_OFS: begin
                    if (q.step == bg_ofs_last) begin
                      d.state    = ST_BG_FILL1;
                      d.step     = '0;
                      d.bg_first = 1'b0;
                    end
                  end
                  ST_BG_FILL1: begin
                    if (q.step == FILL_CONV - 3'h1) begin
                      d.state  = ST_BG_GAIN;
                      d.step   = '0;
                      d.conversion_valid_n_n = 1'b0;
                    end
                  end
                  ST_BG_GAIN: begin
                    if (q.step == GAIN_CONV - 3'h1) begin
                      d.state = ST_BG_FILL2;
                      d.step  = '0;
                    end
                  end
                  default: begin
                    if (q.step == FILL_CONV - 3'h1) begin
                      d.state  = ST_BG_OFS;
                      d.step   = '0;
                      d.conversion_valid_n_n = 1'b0;
                    end
                  end
                endcase
              end
            end
          endcase
          if (d.state == ST_SLEEP) begin
            d.port_awake = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q            <= '0;
      q.state      <= ST_NORMAL;
      q.mode       <= MODE_RESET;
      q.conversion_valid_n_n     <= 1'b1;
      q.port_awake <= 1'b1;
      q.cs_sync    <= 3'h7;
      q.sdio_sync  <= 3'h7;
      q.cs_lvl     <= 1'b1;
      q.sdio_lvl   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    o_cap_sel           = CAP_INPUT;
    o_offset_cal_active = 1'b0;
    o_gain_cal_active   = 1'b0;
    case (q.state)
      ST_SELF_OFS, ST_BG_OFS: begin
        o_cap_sel           = CAP_SHORT;
        o_offset_cal_active = 1'b1;
      end
      ST_PS_OFS, ST_SYS_CAL: begin
        o_offset_cal_active = q.mode != MODE_SYS_FS;
        o_gain_cal_active   = q.mode == MODE_SYS_FS;
      end
      ST_SELF_GAIN, ST_PS_GAIN, ST_BG_GAIN: begin
        o_cap_sel         = CAP_REF;
        o_gain_cal_active = 1'b1;
      end
      default: begin
        o_cap_sel = CAP_INPUT;
      end
    endcase
  end

  assign o_conversion_valid_n   = q.conversion_valid_n_n;
  assign o_operation_mode_field = q.mode;
  assign o_analog_pwr_en        = q.state != ST_SLEEP;
  assign o_bias_pwr_en          = q.bias_en;
  assign o_ref_pwr_en           = q.ref_en;
  assign o_serial_awake         = q.port_awake;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_pseudo_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state == ST_NORMAL && tick && q.mode == MODE_PSEUDO) |=> q.state == ST_PS_OFS)
    else $error("pseudo calibration did not start at boundary");
  a_cal_conversion_valid_n_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state inside {ST_SELF_OFS, ST_SELF_GAIN, ST_PS_OFS, ST_PS_GAIN, ST_SYS_CAL})
    |=> o_conversion_valid_n)
    else $error("data-ready fell during calibration");
  a_ps_ofs_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state == ST_PS_OFS && tick && q.step == (i_slave_mode ? 3'h3 : 3'h2))
    |=> q.state == ST_PS_GAIN)
    else $error("pseudo offset step has wrong length");
  a_ps_gain_ref: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q.state == ST_PS_GAIN |-> o_cap_sel == CAP_REF && q.step < 3'h3)
    else $error("pseudo gain step not on reference");
  a_ps_end_fill: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state == ST_PS_GAIN && tick && q.step == 3'h2)
    |=> q.mode == MODE_NORMAL && q.state == ST_FILL && o_cap_sel == CAP_INPUT)
    else $error("pseudo calibration end wrong");
  a_bg_ofs_short: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state == ST_BG_OFS && !q.bg_first && tick && q.step == 3'h2 && q.mode == MODE_BKGND)
    |=> q.state == ST_BG_FILL1)
    else $error("later background offset not three periods");
  a_bg_fill_conversion_valid_n: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state == ST_BG_FILL1 && tick && q.step == 3'h2 && q.mode == MODE_BKGND)
    |=> !o_conversion_valid_n && q.state == ST_BG_GAIN ##1 o_conversion_valid_n)
    else $error("background result or gain step missing");
  a_bg_loop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state == ST_BG_FILL2 && tick && q.step == 3'h2 && q.mode == MODE_BKGND)
    |=> !o_conversion_valid_n && o_cap_sel == CAP_SHORT)
    else $error("background loop did not restart offset");
  a_sleep_enter: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state == ST_SLEEP && q.mode == MODE_SLEEP) |=> q.state == ST_SLEEP && !o_analog_pwr_en)
    else $error("sleep left without new mode");
  a_wake_conversion_valid_n: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (q.state == ST_WAKE_CONV && tick && q.mode == MODE_NORMAL)
    |=> o_conversion_valid_n && q.suppress)
    else $error("data-ready fell too early after wake");
  a_undef_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_wr && rx_code == MODE_UNDEF && !tick) |=> $stable(o_operation_mode_field))
    else $error("undefined code changed the mode field");

endmodule : acsms_top
`default_nettype wire

// ==== testbench/acsms_host_model.sv ====
// Host side of the serial link: sends one command byte per frame.
// Assumes the core clock is given so frames can be spaced in core cycles.
`timescale 1ns/1ns
`default_nettype none
module acsms_host_model (
  input  wire logic i_clk,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdio
);
  logic raw = 1'b0;
  logic en  = 1'b0;

  // Link clock only runs within a frame
  assign o_sclk = raw & en;

  initial begin
    // The receiver has no other reset: one rising chip select clears it
    o_cs_n = 1'b0;
    o_sdio = 1'b1;
    #2;
    o_cs_n = 1'b1;
    #5;
    forever #16 raw = ~raw;
  end

  // ****************************************************************
  // One frame, MSB first; data moves on the falling link edge
  // ****************************************************************
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    // Give the wake filter time before the first edge
    repeat (5) @(posedge i_clk);
    for (int i = 7; i >= 0; i--) begin
      @(negedge raw);
      o_sdio <= b[i];
      en     <= 1'b1;
    end
    @(negedge raw);
    en     <= 1'b0;
    // Released line shows the inverse, never a stale value
    o_sdio <= ~b[0];
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    repeat (8) @(posedge i_clk);
  endtask : send

  // ****************************************************************
  // Wake without chip select: line high, then a falling edge
  // ****************************************************************
  task automatic sdio_wake();
    @(posedge i_clk);
    o_sdio <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_sdio <= 1'b0;
    repeat (6) @(posedge i_clk);
    o_sdio <= 1'b1;
  endtask : sdio_wake
endmodule : acsms_host_model
`default_nettype wire

// ==== testbench/test_adc_cal_sleep_mode_sequencer.sv ====
// Self-checking bench for the calibration and sleep mode sequencer.
// Assumes a short conversion period (CONV_CYCLES = 8) to keep runs brief.
`timescale 1ns/1ns
`default_nettype none
module test_adc_cal_sleep_mode_sequencer;
  import acsms_pkg::*;
  localparam int P = 8;

  typedef struct {
    logic [2:0] c;
    logic       sl;
    int         o, g, s, r, d0, dd;
  } acsms_case_s;

  logic       clk, rst_n, slave, bias_en, ref_en, sclk, cs_n, sdio;
  logic       conversion_valid_n_n, ofs, gain, apwr, bpwr, rpwr, awake;
  logic [2:0] mode;
  acsms_cap_e cap;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         cyc = 0, os = -1, dn = 0, k;
  int         d[2];
  int         n_ofs, n_gain, n_short, n_ref;
  // Mode, slave, offset, gain, shorted, reference, first result, spacing (periods)
  acsms_case_s tbl[7] = '{
    '{MODE_PSEUDO, 1'b0, 3, 3, 0, 3, 9, 1}, '{MODE_PSEUDO, 1'b1, 4, 3, 0, 3, 10, 1},
    '{MODE_SELF, 1'b0, 3, 3, 3, 3, 9, 1}, '{MODE_SYS_OFS, 1'b1, 4, 0, 0, 0, 5, 1},
    '{MODE_BKGND, 1'b1, 4, 3, 4, 3, 7, 6}, '{MODE_BKGND, 1'b0, 3, 3, 3, 3, 6, 6},
    '{MODE_SYS_FS, 1'b0, 0, 3, 0, 0, 4, 1}};

  acsms_host_model host (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdio(sdio));

  acsms_top #(.CONV_CYCLES(P)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdio(sdio),
    .i_slave_mode(slave), .i_bias_enable(bias_en), .i_internal_ref_output_enable(ref_en),
    .o_conversion_valid_n(conversion_valid_n_n), .o_operation_mode_field(mode), .o_cap_sel(cap),
    .o_offset_cal_active(ofs), .o_gain_cal_active(gain), .o_analog_pwr_en(apwr),
    .o_bias_pwr_en(bpwr), .o_ref_pwr_en(rpwr), .o_serial_awake(awake));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************************************
  // Monitor, sampled mid-cycle to stay clear of the update edge
  // ****************************************************************
  always @(negedge clk) begin
    cyc++;
    if (os < 0 && (ofs === 1'b1 || gain === 1'b1)) os = cyc;
    if (os >= 0 && dn < 2) begin
      if (conversion_valid_n_n === 1'b0) begin
        d[dn] = cyc;
        dn++;
      end
      if (dn < 2) begin
        n_ofs   += int'(ofs === 1'b1);
        n_gain  += int'(gain === 1'b1);
        n_short += int'(cap === CAP_SHORT);
        n_ref   += int'(cap === CAP_REF);
      end
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("mismatch watchdog expected finish seen hang");
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    slave = 1'b0;
    bias_en = 1'b0;
    ref_en = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("mode_rst", mode, MODE_RESET);
    chk("conversion_valid_n_rst", conversion_valid_n_n, 1'b1);
    chk("apwr_rst", apwr, 1'b1);
    chk("awake_rst", awake, 1'b1);
    $display("test reset done");

    foreach (tbl[i]) begin
      @(posedge clk);
      slave <= tbl[i].sl;
      os = -1;
      dn = 0;
      n_ofs = 0;
      n_gain = 0;
      n_short = 0;
      n_ref = 0;
      host.send({5'h10, tbl[i].c});
      for (int j = 0; j < 60 * P && dn < 2; j++) @(posedge clk);
      chk("ofs_len", n_ofs, tbl[i].o * P);
      chk("gain_len", n_gain, tbl[i].g * P);
      chk("short_len", n_short, tbl[i].s * P);
      chk("ref_len", n_ref, tbl[i].r * P);
      chk("first_conversion_valid_n", d[0] - os, tbl[i].d0 * P);
      chk("conversion_valid_n_gap", d[1] - d[0], tbl[i].dd * P);
      if (tbl[i].c == MODE_BKGND) begin
        chk("bg_mode", mode, MODE_BKGND);
        host.send(8'h80);
        repeat (2 * P) @(posedge clk);
      end
      @(negedge clk);
      chk("mode_after", mode, MODE_NORMAL);
      $display("test calibration case %0d done", i);
    end

    host.send(8'h87);
    repeat (2 * P) @(posedge clk);
    @(negedge clk);
    chk("mode_undef", mode, MODE_NORMAL);
    $display("test undefined code done");

    @(posedge clk);
    bias_en <= 1'b1;
    host.send(8'h86);
    repeat (2 * P) @(posedge clk);
    @(negedge clk);
    chk("sleep_mode", mode, MODE_SLEEP);
    chk("sleep_apwr", apwr, 1'b0);
    chk("sleep_bias", bpwr, 1'b1);
    chk("sleep_ref", rpwr, 1'b0);
    chk("sleep_awake", awake, 1'b0);
    @(posedge clk);
    ref_en <= 1'b1;
    fork
      host.send(8'h80);
      begin
        for (int j = 0; j < 60 * P && mode !== MODE_NORMAL; j++) @(negedge clk);
        for (k = 0; k < 60 * P && conversion_valid_n_n !== 1'b0; k++) @(negedge clk);
      end
    join
    chk("wake_late", k > PWRUP_CYCLES + 2 * P + 1, 1'b1);
    chk("wake_soon", k <= PWRUP_CYCLES + 4 * P, 1'b1);
    chk("wake_apwr", apwr, 1'b1);
    chk("wake_ref", rpwr, 1'b1);
    $display("test sleep and wake done");
    host.send(8'h86);
    repeat (2 * P) @(posedge clk);
    @(negedge clk);
    chk("sleep2_awake", awake, 1'b0);
    host.sdio_wake();
    @(negedge clk);
    chk("sdio_wake", awake, 1'b1);
    $display("test data line wake done");
    summarize();
  end
endmodule : test_adc_cal_sleep_mode_sequencer
`default_nettype wire
